/* File: dbg_comm_regs.sv */
// debug link override control and die identifier register slice
// Notes on behaviour
// - ID bytes five-nine reset zero, load from memory
// - unlock code register; right code lifts override lock
// - bits six, five enable low-side tx, rx
// - bits four, three enable high-side tx, rx
// - bit two forces fixed 250kb/s chain rate
// - bit one enables user host-UART override
// - status bits show live port enable states
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "dbg_regs.svh"
module dbg_comm_regs
    import dbg_pkg::*;
#(
    // code that lifts the lock (value arbitrary)
    parameter logic [7:0] UNLOCK_KEY = 8'ha5
)(
    // clock and reset
    input  wire logic                 CLK,
    input  wire logic                 RST,
    // write address channel
    input  wire logic [`AXI_AW-1:0]   AWADDR,
    input  wire logic                 AWVALID,
    output logic                      AWREADY,
    // write data channel
    input  wire logic [31:0]          WDATA,
    input  wire logic [3:0]           WSTRB,
    input  wire logic                 WVALID,
    output logic                      WREADY,
    // write response channel
    output logic [1:0]                BRESP,
    output logic                      BVALID,
    input  wire logic                 BREADY,
    // read address channel
    input  wire logic [`AXI_AW-1:0]   ARADDR,
    input  wire logic                 ARVALID,
    output logic                      ARREADY,
    // read data channel
    output logic [31:0]               RDATA,
    output logic [1:0]                RRESP,
    output logic                      RVALID,
    input  wire logic                 RREADY,
    // factory memory load
    input  wire logic                 NVM_LOAD_OK,
    input  wire logic [39:0]          NVM_ID_DATA,
    // device-driven port enables used while override is off
    input  wire logic [3:0]           DEV_PORT_EN,
    // port enables toward the daisy physical layer
    output logic                      LOW_SIDE_TX_ENABLE,
    output logic                      LOW_SIDE_RX_ENABLE,
    output logic                      HIGH_SIDE_TX_ENABLE,
    output logic                      HIGH_SIDE_RX_ENABLE,
    // chain rate and uart override
    output logic                      FORCED_CHAIN_RATE_SELECT,
    output logic                      USER_UART_OVERRIDE
);
    // bus state per direction
    bus_state_t       wr_st_ff, rd_st_ff;
    // latched write address and data
    logic [`AXI_AW-1:0] aw_ff;
    logic               aw_have_ff;
    logic [31:0]        w_ff;
    logic [3:0]         ws_ff;
    logic               w_have_ff;
    // response registers
    logic [1:0]         bresp_ff, rresp_ff;
    logic [31:0]        rdata_ff;
    // software registers
    byte_t              unlock_ff;
    logic [6:0]         ctrl_ff;
    logic               unlocked_ff;
    // port state outputs
    logic [3:0]         port_ff;
    // identifier bytes
    byte_t              id_byte [5];
    // write fire when both halves held
    logic               wr_go;
    logic               wr_hit_unlock, wr_hit_ctrl;
    // register lookup for the held write address and the offered read address
    logic [8:0]         wr_look, rd_look;

    // map byte address to register index; the low two bits are ignored
    function automatic logic [15:0] to_idx(input logic [`AXI_AW-1:0] a);
        to_idx = a[`AXI_AW-1:2];
    endfunction : to_idx

    // read mux for one register index
    function automatic logic [8:0] rd_val(input logic [15:0] idx);
        case (idx)
            `IDX_DIE_IDENTIFIER_BYTE5:  rd_val = {1'b1, id_byte[0]};
            `IDX_DIE_IDENTIFIER_BYTE6:  rd_val = {1'b1, id_byte[1]};
            `IDX_DIE_IDENTIFIER_BYTE7:  rd_val = {1'b1, id_byte[2]};
            `IDX_DIE_IDENTIFIER_BYTE8:  rd_val = {1'b1, id_byte[3]};
            `IDX_DIE_IDENTIFIER_BYTE9:  rd_val = {1'b1, id_byte[4]};
            `IDX_UNLOCK:   rd_val = {1'b1, unlock_ff};
            `IDX_OVR_CTRL: rd_val = {1'b1, 1'b0, ctrl_ff};
            `IDX_OVR_STAT: rd_val = {1'b1, 3'h0, ctrl_ff[`CTL_DAISY_BIT], port_ff};
            default:       rd_val = 9'h000;
        endcase
    endfunction : rd_val

    // identifier byte store
    dbg_id_bank u_id (
        .clk       (CLK),
        .rst       (RST),
        .load_ok   (NVM_LOAD_OK),
        .load_data (NVM_ID_DATA),
        .id_byte   (id_byte)
    );

    // look up both addresses; always_comb also follows the registers read inside rd_val
    always_comb begin
        wr_look = rd_val(to_idx(aw_ff));
        rd_look = rd_val(to_idx(ARADDR));
    end

    // handshake outputs
    assign AWREADY = (wr_st_ff == ST_IDLE) && !aw_have_ff;
    assign WREADY  = (wr_st_ff == ST_IDLE) && !w_have_ff;
    assign ARREADY = (rd_st_ff == ST_IDLE);
    assign BVALID  = (wr_st_ff == ST_RESP);
    assign RVALID  = (rd_st_ff == ST_RESP);
    assign BRESP   = bresp_ff;
    assign RRESP   = rresp_ff;
    assign RDATA   = rdata_ff;

    // write happens once address and data are both latched
    assign wr_go         = aw_have_ff && w_have_ff && (wr_st_ff == ST_IDLE);
    assign wr_hit_unlock = wr_go && ws_ff[0] && (to_idx(aw_ff) == `IDX_UNLOCK);
    assign wr_hit_ctrl   = wr_go && ws_ff[0] && (to_idx(aw_ff) == `IDX_OVR_CTRL);

    // latch write address and data in either order
    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_ff      <= '0;
            aw_have_ff <= 1'b0;
            w_ff       <= 32'h0000_0000;
            ws_ff      <= 4'h0;
            w_have_ff  <= 1'b0;
        end else if (wr_go) begin
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_ff      <= AWADDR;
                aw_have_ff <= 1'b1;
            end
            if (WVALID && WREADY) begin
                w_ff      <= WDATA;
                ws_ff     <= WSTRB;
                w_have_ff <= 1'b1;
            end
        end
    end

    // write response state and code
    always_ff @(posedge CLK) begin
        if (RST) begin
            wr_st_ff <= ST_IDLE;
            bresp_ff <= `RESP_OKAY;
        end else begin
            case (wr_st_ff)
                ST_IDLE: begin
                    if (wr_go) begin
                        wr_st_ff <= ST_RESP;
                        // mapped registers answer okay, id writes are silently dropped
                        bresp_ff <= wr_look[8] ? `RESP_OKAY : `RESP_SLVERR;
                    end
                end
                ST_RESP: begin
                    if (BREADY) begin
                        wr_st_ff <= ST_IDLE;
                    end
                end
                default: wr_st_ff <= ST_IDLE;
            endcase
        end
    end

    // read channel: data one cycle after address taken
    always_ff @(posedge CLK) begin
        if (RST) begin
            rd_st_ff <= ST_IDLE;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `RESP_OKAY;
        end else begin
            case (rd_st_ff)
                ST_IDLE: begin
                    if (ARVALID) begin
                        rd_st_ff <= ST_RESP;
                        rdata_ff <= {24'h00_0000, rd_look[7:0]};
                        rresp_ff <= rd_look[8] ? `RESP_OKAY : `RESP_SLVERR;
                    end
                end
                ST_RESP: begin
                    if (RREADY) begin
                        rd_st_ff <= ST_IDLE;
                    end
                end
                default: rd_st_ff <= ST_IDLE;
            endcase
        end
    end

    // unlock code register and lock state
    always_ff @(posedge CLK) begin
        if (RST) begin
            unlock_ff   <= `RST_UNLOCK;
            unlocked_ff <= 1'b0;
        end else if (wr_hit_unlock) begin
            unlock_ff   <= w_ff[7:0];
            unlocked_ff <= (w_ff[7:0] == UNLOCK_KEY);
        end
    end

    // control register; bit seven is not stored
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_ff <= `RST_CTRL;
        end else if (wr_hit_ctrl) begin
            ctrl_ff <= w_ff[6:0];
        end
    end

    // port enables: user bits only when override set and unlocked
    always_ff @(posedge CLK) begin
        if (RST) begin
            port_ff <= `DEV_PORT_EN;
        end else if (ctrl_ff[`CTL_DAISY_BIT] && unlocked_ff) begin
            port_ff <= ctrl_ff[`CTL_LTX_BIT:`CTL_HRX_BIT];
        end else begin
            port_ff <= DEV_PORT_EN;
        end
    end

    // drive daisy ports from the selected enables
    assign LOW_SIDE_TX_ENABLE  = port_ff[3];
    assign LOW_SIDE_RX_ENABLE  = port_ff[2];
    assign HIGH_SIDE_TX_ENABLE = port_ff[1];
    assign HIGH_SIDE_RX_ENABLE = port_ff[0];
    // rate force and uart override straight from control bits
    assign FORCED_CHAIN_RATE_SELECT = ctrl_ff[`CTL_RATE_BIT];
    assign USER_UART_OVERRIDE       = ctrl_ff[`CTL_UART_BIT];
endmodule : dbg_comm_regs

/* File: dbg_comm_regs_checker.sv */
// assertions on the port behaviour of the debug register slice
`timescale 1ns/1ps
module dbg_comm_regs_checker
    import dbg_pkg::*;
(
    // clock and reset
    input wire logic        CLK,
    input wire logic        RST,
    // bus handshakes
    input wire logic        AWVALID,
    input wire logic        AWREADY,
    input wire logic        WVALID,
    input wire logic        WREADY,
    input wire logic [1:0]  BRESP,
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0]  RRESP,
    input wire logic        RVALID,
    input wire logic        RREADY,
    // port enables and modes
    input wire logic        LOW_SIDE_TX_ENABLE,
    input wire logic        LOW_SIDE_RX_ENABLE,
    input wire logic        HIGH_SIDE_TX_ENABLE,
    input wire logic        HIGH_SIDE_RX_ENABLE,
    input wire logic        FORCED_CHAIN_RATE_SELECT,
    input wire logic        USER_UART_OVERRIDE
);
    // all checks on the one clock, quiet during reset except rst_out_a
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // answers stand until taken
    b_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped early");
    r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped early");
    // write answers two cycles after both halves are taken, read one cycle after
    w_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY |=> ##1 BVALID)
        else $error("write response late");
    r_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read data late");
    // no new write while a response waits
    w_busy_a: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write accepted while busy");
    // byte registers and refused reads
    r_upper_a: assert property (RVALID |-> RDATA[31:8] == 24'h0)
        else $error("upper read bits set");
    err_data_a: assert property (RVALID && RRESP == 2'b10 |-> RDATA == 32'h0)
        else $error("refused read carries data");
    // reset state of the outputs
    rst_out_a: assert property (disable iff (1'b0) RST |=> {LOW_SIDE_TX_ENABLE,
        LOW_SIDE_RX_ENABLE, HIGH_SIDE_TX_ENABLE, HIGH_SIDE_RX_ENABLE,
        FORCED_CHAIN_RATE_SELECT, USER_UART_OVERRIDE} == 6'h3c)
        else $error("outputs wrong after reset");
    // rate only moves on a register write
    rate_write_a: assert property ($changed(FORCED_CHAIN_RATE_SELECT) |->
        BVALID || $past(BVALID))
        else $error("rate changed without write");
    // main scenarios
    wr_c: cover property (BVALID && BREADY);
    err_c: cover property (RVALID && RRESP == 2'b10);
    rate_c: cover property ($rose(FORCED_CHAIN_RATE_SELECT));
endmodule : dbg_comm_regs_checker

bind dbg_comm_regs dbg_comm_regs_checker chk_i (.CLK(CLK), .RST(RST), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .LOW_SIDE_TX_ENABLE(LOW_SIDE_TX_ENABLE),
    .LOW_SIDE_RX_ENABLE(LOW_SIDE_RX_ENABLE), .HIGH_SIDE_TX_ENABLE(HIGH_SIDE_TX_ENABLE),
    .HIGH_SIDE_RX_ENABLE(HIGH_SIDE_RX_ENABLE), .USER_UART_OVERRIDE(USER_UART_OVERRIDE),
    .FORCED_CHAIN_RATE_SELECT(FORCED_CHAIN_RATE_SELECT));

/* File: dbg_id_bank.sv */
// die identifier byte store loaded from factory memory on every load_ok pulse
`timescale 1ns/1ps
`include "dbg_regs.svh"
module dbg_id_bank
    import dbg_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // factory memory load
    input  wire logic        load_ok,
    input  wire logic [39:0] load_data,
    // stored bytes, five through nine
    output byte_t            id_byte [5]
);
    // captured identifier bytes
    byte_t id_ff [5];

    // capture bytes on a successful load; no bus path can write here
    always_ff @(posedge clk) begin
        for (int i = 0; i < 5; i++) begin
            if (rst) begin
                id_ff[i] <= `RST_ID;
            end else if (load_ok) begin
                id_ff[i] <= load_data[i*8 +: 8];
            end
        end
    end

    // present stored bytes
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            id_byte[i] = id_ff[i];
        end
    end
endmodule : dbg_id_bank

/* File: dbg_pkg.sv */
// types shared by the debug register slice
package dbg_pkg;
    // bus slave states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RESP = 2'b10
    } bus_state_t;
    // byte wide register value
    typedef logic [7:0] byte_t;
endpackage : dbg_pkg

/* File: dbg_regs.svh */
// register offsets, field positions, reset values and constants
`ifndef DBG_REGS_SVH
`define DBG_REGS_SVH

// register indices; the byte address on the bus is the index times four
`define IDX_DIE_IDENTIFIER_BYTE5        16'h2125
`define IDX_DIE_IDENTIFIER_BYTE6        16'h2126
`define IDX_DIE_IDENTIFIER_BYTE7        16'h2127
`define IDX_DIE_IDENTIFIER_BYTE8        16'h2128
`define IDX_DIE_IDENTIFIER_BYTE9        16'h2129
`define IDX_UNLOCK         16'h2200
`define IDX_OVR_CTRL       16'h2201
`define IDX_OVR_STAT       16'h2300
// address width of the bus
`define AXI_AW             18
// control register field positions
`define CTL_LTX_BIT        6
`define CTL_LRX_BIT        5
`define CTL_HTX_BIT        4
`define CTL_HRX_BIT        3
`define CTL_RATE_BIT       2
`define CTL_UART_BIT       1
`define CTL_DAISY_BIT      0
// reset values
`define RST_ID             8'h00
`define RST_UNLOCK         8'h00
`define RST_CTRL           7'h78
// default device-driven port enables (all ports on)
`define DEV_PORT_EN        4'hf
// response codes
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

/* File: tb_dbg_comm_regs.sv */
// self-checking bench for the debug register slice
`timescale 1ns/1ps
`include "dbg_regs.svh"
module tb_dbg_comm_regs
    import dbg_pkg::*;
;
    // bench-driven inputs, all set at time zero
    logic CLK = 0, RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic [17:0] AWADDR = '0, ARADDR = '0;
    logic [31:0] WDATA = '0;
    logic [3:0]  WSTRB = 4'hf, DEV_PORT_EN = 4'hf;
    logic        NVM_LOAD_OK = 0;
    logic [39:0] NVM_ID_DATA = '0;
    // design outputs
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, LTX, LRX, HTX, HRX, RATE, UART;
    logic [1:0]  BRESP, RRESP;
    logic [31:0] RDATA;
    int errors = 0, tests_run = 0;
    localparam logic [1:0] OK = `RESP_OKAY, ER = `RESP_SLVERR;
    // free running clock
    always #2 CLK = ~CLK;
    dbg_comm_regs uut (.CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .NVM_LOAD_OK(NVM_LOAD_OK), .NVM_ID_DATA(NVM_ID_DATA), .DEV_PORT_EN(DEV_PORT_EN),
        .LOW_SIDE_TX_ENABLE(LTX), .LOW_SIDE_RX_ENABLE(LRX), .HIGH_SIDE_TX_ENABLE(HTX),
        .HIGH_SIDE_RX_ENABLE(HRX), .FORCED_CHAIN_RATE_SELECT(RATE), .USER_UART_OVERRIDE(UART));
    // byte address from register index
    function automatic logic [17:0] ad(input logic [15:0] i);
        return {i, 2'b00};
    endfunction : ad
    // compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // bus write: address and data together, response awaited
    task automatic wr(input logic [15:0] i, input logic [7:0] d, input logic [1:0] r);
        @(posedge CLK);
        AWADDR <= ad(i); WDATA <= {24'h0, d}; AWVALID <= 1; WVALID <= 1; BREADY <= 1;
        do begin
            @(posedge CLK);
            if (AWREADY) AWVALID <= 0;
            if (WREADY) WVALID <= 0;
        end while (BVALID !== 1'b1);
        BREADY <= 0;
        chk({30'h0, BRESP}, {30'h0, r});
    endtask : wr
    // bus read with expected byte and response
    task automatic rd(input logic [15:0] i, input logic [7:0] e, input logic [1:0] r);
        @(posedge CLK);
        ARADDR <= ad(i); ARVALID <= 1; RREADY <= 1;
        do begin
            @(posedge CLK);
            if (ARREADY) ARVALID <= 0;
        end while (RVALID !== 1'b1);
        RREADY <= 0;
        chk(RDATA, {24'h0, e});
        chk({30'h0, RRESP}, {30'h0, r});
    endtask : rd
    // port enables once the change has landed
    task automatic pchk(input logic [3:0] e);
        repeat (2) @(posedge CLK);
        chk({28'h0, LTX, LRX, HTX, HRX}, {28'h0, e});
    endtask : pchk
    // verdict, reached from the tests or the watchdog
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    // watchdog
    initial begin
        #20000;
        errors++;
        final_report();
    end
    // test sequence
    initial begin
        repeat (20) @(posedge CLK);
        RST <= 0;
        for (int i = 0; i < 5; i++) rd(`IDX_DIE_IDENTIFIER_BYTE5 + i, 8'h00, OK);
        rd(`IDX_UNLOCK, 8'h00, OK);
        rd(`IDX_OVR_CTRL, 8'h78, OK);
        rd(`IDX_OVR_STAT, 8'h0f, OK);
        pchk(4'hf);
        // one factory load pulse
        @(posedge CLK);
        NVM_ID_DATA <= 40'h9988776655; NVM_LOAD_OK <= 1;
        @(posedge CLK);
        NVM_LOAD_OK <= 0;
        for (int i = 0; i < 5; i++) rd(`IDX_DIE_IDENTIFIER_BYTE5 + i, 8'h55 + 8'h11 * i, OK);
        wr(`IDX_DIE_IDENTIFIER_BYTE7, 8'h00, OK);
        rd(`IDX_DIE_IDENTIFIER_BYTE7, 8'h77, OK);
        // locked: override bit set but ports stay with the device
        DEV_PORT_EN <= 4'h5;
        wr(`IDX_OVR_CTRL, 8'hd1, OK);
        rd(`IDX_OVR_CTRL, 8'h51, OK);
        pchk(4'h5);
        wr(`IDX_UNLOCK, 8'ha5, OK);
        rd(`IDX_UNLOCK, 8'ha5, OK);
        pchk(4'ha);
        rd(`IDX_OVR_STAT, 8'h1a, OK);
        // override off, rate and uart on
        wr(`IDX_OVR_CTRL, 8'h66, OK);
        pchk(4'h5);
        chk({30'h0, RATE, UART}, 32'h3);
        rd(`IDX_OVR_STAT, 8'h05, OK);
        DEV_PORT_EN <= 4'hc;
        wr(`IDX_OVR_CTRL, 8'h29, OK);
        pchk(4'h5);
        chk({30'h0, RATE, UART}, 32'h0);
        // a wrong code locks again
        wr(`IDX_UNLOCK, 8'h3c, OK);
        pchk(4'hc);
        // a write with byte lane zero off leaves the code alone
        WSTRB <= 4'he;
        wr(`IDX_UNLOCK, 8'h00, OK);
        rd(`IDX_UNLOCK, 8'h3c, OK);
        WSTRB <= 4'hf;
        // unmapped place is refused
        wr(16'h0001, 8'h12, ER);
        rd(16'h0001, 8'h00, ER);
        final_report();
    end
endmodule : tb_dbg_comm_regs
